// ==== design/ldc_pkg.sv ====
// Constants, field layout, timing and types for the line driver control registers.
// Assumes a single 25 MHz system clock and an active-low asynchronous reset.
// Contract
// - With limit enabled, the two-bit field selects 50, 100, 200 or 250 mA.
// - Limit-disable at one removes current limiting from both drivers.
// - Blanking field selects 128 us, 500 us, 1 ms or 5 ms.
// - A fault is not signalled before it lasts the selected blanking time.
// - Retry field selects off-time 50, 100, 200 or 500 ms.
// - With auto-retry on, a fault switches drivers off for the off-time, then back on.
// - With auto-retry off, a faulted driver stays off until die temperature drops.
// - Receiver-disable at one puts received-data output at high impedance.
// - Two bits enable weak pull-down and weak pull-up on the line driver.
// - Tracking at one makes the aux driver follow the line driver's source.
// - Without push-pull, NPN-select picks NPN at one, PNP at zero.
// - Push-pull bit selects push-pull at one, open-drain at zero.
// - Output bit one drives high, PNP on, or NPN off depending on mode.
// - Output bit zero with enable low or disable set gives high impedance.
// - Output bit zero, enable high, disable clear: line is inverse of transmit data.
// - Line disable forces high impedance and resets to one.
// - Per-driver fault flag is set while a qualified fault is present, clears after.
`default_nettype none

package ldc_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1_000;

  localparam int unsigned BLANK_0_US = 128;
  localparam int unsigned BLANK_1_US = 500;
  localparam int unsigned BLANK_2_US = 1000;
  localparam int unsigned BLANK_3_US = 5000;
  localparam int unsigned RETRY_0_MS = 50;
  localparam int unsigned RETRY_1_MS = 100;
  localparam int unsigned RETRY_2_MS = 200;
  localparam int unsigned RETRY_3_MS = 500;

  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] BLANK_0_CYC = CNT_W'(BLANK_0_US * CLK_PER_US);
  localparam logic [CNT_W-1:0] BLANK_1_CYC = CNT_W'(BLANK_1_US * CLK_PER_US);
  localparam logic [CNT_W-1:0] BLANK_2_CYC = CNT_W'(BLANK_2_US * CLK_PER_US);
  localparam logic [CNT_W-1:0] BLANK_3_CYC = CNT_W'(BLANK_3_US * CLK_PER_US);
  localparam logic [CNT_W-1:0] RETRY_0_CYC = CNT_W'(RETRY_0_MS * CLK_PER_MS);
  localparam logic [CNT_W-1:0] RETRY_1_CYC = CNT_W'(RETRY_1_MS * CLK_PER_MS);
  localparam logic [CNT_W-1:0] RETRY_2_CYC = CNT_W'(RETRY_2_MS * CLK_PER_MS);
  localparam logic [CNT_W-1:0] RETRY_3_CYC = CNT_W'(RETRY_3_MS * CLK_PER_MS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;

  // Register indexes; the byte address is four times the index.
  localparam logic [3:0] IDX_LIMIT_CFG = 4'h3;
  localparam logic [3:0] IDX_LINE_CFG = 4'h4;
  localparam logic [3:0] IDX_AUX_CFG = 4'h5;
  localparam logic [3:0] IDX_FAULT_STATUS = 4'h6;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'h7;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h8;

  localparam logic [7:0] LIMIT_CFG_RESET = 8'h00;
  localparam logic [7:0] LINE_CFG_RESET = 8'h01;
  localparam logic [7:0] AUX_CFG_RESET = 8'h01;
  localparam logic [7:0] AUX_CFG_WMASK = 8'h7f;

  // Current limit configuration fields.
  localparam int LIM_SEL_LO = 6;
  localparam int LIM_DIS = 5;
  localparam int BLK_SEL_LO = 3;
  localparam int RTY_SEL_LO = 1;
  localparam int RETRY_EN = 0;

  // Line and aux driver configuration fields.
  localparam int RX_DIS = 7;
  localparam int WPD = 6;
  localparam int WPU = 5;
  localparam int TRACK = 4;
  localparam int NPN_SEL = 3;
  localparam int PUSH_PULL = 2;
  localparam int OUT_BIT = 1;
  localparam int DRV_DIS = 0;

  // Interrupt status and mask bits.
  localparam int IRQ_LINE_FAULT = 0;
  localparam int IRQ_AUX_FAULT = 1;
  localparam int IRQ_W = 2;

  localparam logic [7:0] LIMIT_50_MA = 8'h32;
  localparam logic [7:0] LIMIT_100_MA = 8'h64;
  localparam logic [7:0] LIMIT_200_MA = 8'hc8;
  localparam logic [7:0] LIMIT_250_MA = 8'hfa;

  typedef enum logic [1:0] {
    FT_IDLE = 2'b00,
    FT_BLANK = 2'b01,
    FT_OFF_TIMED = 2'b10,
    FT_OFF_HOT = 2'b11
  } fault_state_t;

  function automatic logic [7:0] limit_ma(input logic [1:0] code);
    case (code)
      2'b00: limit_ma = LIMIT_50_MA;
      2'b01: limit_ma = LIMIT_100_MA;
      2'b10: limit_ma = LIMIT_200_MA;
      default: limit_ma = LIMIT_250_MA;
    endcase
  endfunction : limit_ma

endpackage : ldc_pkg

`default_nettype wire

// ==== design/drive_logic.sv ====
// Combinational switch decode for one high-voltage output driver.
// Assumes the enclosing module registers the switch commands.
`default_nettype none

module drive_logic
  import ldc_pkg::*;
(
  input wire logic enable_i,
  input wire logic disable_i,
  input wire logic out_bit_i,
  input wire logic push_pull_i,
  input wire logic npn_i,
  input wire logic tx_en_i,
  input wire logic tx_data_i,
  output logic high_on_o,
  output logic low_on_o
);

  logic active;
  logic level;

  always_comb begin
    // Disable and a fault shutdown override every other source.
    active = enable_i && !disable_i && (out_bit_i || tx_en_i);
    level = out_bit_i || !tx_data_i;
    high_on_o = 1'b0;
    low_on_o = 1'b0;
    if (active) begin
      if (push_pull_i) begin
        high_on_o = level;
        low_on_o = !level;
      end else if (npn_i) begin
        low_on_o = !level;
      end else begin
        high_on_o = level;
      end
    end
  end

endmodule : drive_logic

`default_nettype wire

// ==== design/fault_timer.sv ====
// Blanking and shutdown sequencing for one driver after an overcurrent or thermal fault.
// Assumes fault and temperature inputs are synchronous to clk_i.
`default_nettype none

module fault_timer
  import ldc_pkg::*;
#(
  parameter logic [CNT_W-1:0] BLANK_CYC_0 = BLANK_0_CYC,
  parameter logic [CNT_W-1:0] BLANK_CYC_1 = BLANK_1_CYC,
  parameter logic [CNT_W-1:0] BLANK_CYC_2 = BLANK_2_CYC,
  parameter logic [CNT_W-1:0] BLANK_CYC_3 = BLANK_3_CYC,
  parameter logic [CNT_W-1:0] RETRY_CYC_0 = RETRY_0_CYC,
  parameter logic [CNT_W-1:0] RETRY_CYC_1 = RETRY_1_CYC,
  parameter logic [CNT_W-1:0] RETRY_CYC_2 = RETRY_2_CYC,
  parameter logic [CNT_W-1:0] RETRY_CYC_3 = RETRY_3_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic fault_cond_i,
  input wire logic temp_above_hyst_i,
  input wire logic auto_retry_i,
  input wire logic [1:0] blank_sel_i,
  input wire logic [1:0] retry_sel_i,
  output logic driver_on_o,
  output logic fault_flag_o,
  output logic fault_event_o
);

  typedef struct packed {
    fault_state_t state;
    logic [CNT_W-1:0] count;
    logic flag;
    logic event_pulse;
  } timer_state_t;

  timer_state_t st;
  timer_state_t next_st;
  logic [CNT_W-1:0] blank_load;
  logic [CNT_W-1:0] retry_load;
  logic expired;

  function automatic logic [CNT_W-1:0] pick(input logic [1:0] sel, input logic [CNT_W-1:0] c0,
      input logic [CNT_W-1:0] c1, input logic [CNT_W-1:0] c2, input logic [CNT_W-1:0] c3);
    case (sel)
      2'b00: pick = c0 - CNT_ONE;
      2'b01: pick = c1 - CNT_ONE;
      2'b10: pick = c2 - CNT_ONE;
      default: pick = c3 - CNT_ONE;
    endcase
  endfunction : pick

  assign blank_load = pick(blank_sel_i, BLANK_CYC_0, BLANK_CYC_1, BLANK_CYC_2, BLANK_CYC_3);
  assign retry_load = pick(retry_sel_i, RETRY_CYC_0, RETRY_CYC_1, RETRY_CYC_2, RETRY_CYC_3);
  assign expired = (st.state == FT_BLANK) && (st.count == CNT_ZERO) && fault_cond_i;

  always_comb begin
    next_st = st;
    next_st.flag = fault_cond_i && (st.flag || expired);
    next_st.event_pulse = next_st.flag && !st.flag;
    if (st.count != CNT_ZERO) begin
      next_st.count = st.count - CNT_ONE;
    end
    case (st.state)
      FT_IDLE: begin
        if (fault_cond_i) begin
          next_st.state = FT_BLANK;
          next_st.count = blank_load;
        end
      end
      FT_BLANK: begin
        if (!fault_cond_i) begin
          next_st.state = FT_IDLE;
        end else if (expired) begin
          if (auto_retry_i) begin
            next_st.state = FT_OFF_TIMED;
            next_st.count = retry_load;
          end else begin
            next_st.state = FT_OFF_HOT;
          end
        end
      end
      FT_OFF_TIMED: begin
        if (st.count == CNT_ZERO) begin
          next_st.state = FT_IDLE;
        end
      end
      FT_OFF_HOT: begin
        if (!temp_above_hyst_i) begin
          next_st.state = FT_IDLE;
        end
      end
      default: next_st.state = FT_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '{state: FT_IDLE, count: CNT_ZERO, flag: 1'b0, event_pulse: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign driver_on_o = (st.state == FT_IDLE) || (st.state == FT_BLANK);
  assign fault_flag_o = st.flag;
  assign fault_event_o = st.event_pulse;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_off_last;
    (st.state == FT_OFF_TIMED) && (st.count == CNT_ZERO);
  endsequence

  sequence s_back_on;
    (st.state == FT_IDLE) && driver_on_o;
  endsequence

  a_flag_needs_cond: assert property (fault_flag_o |-> $past(fault_cond_i))
    else $error("fault flag set without a fault");
  a_blank_keeps_on: assert property ((st.state == FT_BLANK) && !expired |=> driver_on_o && !$rose(fault_flag_o))
    else $error("driver off or flagged during blanking");
  a_blank_load: assert property ((st.state == FT_IDLE) && fault_cond_i |=> st.count == $past(blank_load))
    else $error("blanking count not loaded from selection");
  a_retry_end: assert property (s_off_last |=> s_back_on)
    else $error("driver not re-enabled after off-time");
  a_hot_holds: assert property ((st.state == FT_OFF_HOT) && temp_above_hyst_i |=> !driver_on_o)
    else $error("driver re-enabled while still hot");
  a_short_fault: assert property ((st.state == FT_BLANK) && !fault_cond_i |=> s_back_on ##1 !fault_flag_o)
    else $error("short fault did not leave driver enabled");

endmodule : fault_timer

`default_nettype wire

// ==== design/line_driver_control_regs.sv ====
// Register bank and output control for the line driver and the auxiliary driver.
// Assumes an Avalon-MM master on the clock domain of CLK_I and synchronous pin inputs.
//
// Register access over Avalon-MM was decided locally.
`default_nettype none

module line_driver_control_regs
  import ldc_pkg::*;
#(
  parameter logic [CNT_W-1:0] BLANK_CYC_0 = BLANK_0_CYC,
  parameter logic [CNT_W-1:0] BLANK_CYC_1 = BLANK_1_CYC,
  parameter logic [CNT_W-1:0] BLANK_CYC_2 = BLANK_2_CYC,
  parameter logic [CNT_W-1:0] BLANK_CYC_3 = BLANK_3_CYC,
  parameter logic [CNT_W-1:0] RETRY_CYC_0 = RETRY_0_CYC,
  parameter logic [CNT_W-1:0] RETRY_CYC_1 = RETRY_1_CYC,
  parameter logic [CNT_W-1:0] RETRY_CYC_2 = RETRY_2_CYC,
  parameter logic [CNT_W-1:0] RETRY_CYC_3 = RETRY_3_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic TX_DATA_I,
  input wire logic TRANSMIT_ENABLE_IN_I,
  input wire logic AUX_LEVEL_I,
  input wire logic LINE_RX_LEVEL_I,
  input wire logic LINE_OVERCURRENT_I,
  input wire logic LINE_OVERTEMP_I,
  input wire logic AUX_OVERCURRENT_I,
  input wire logic AUX_OVERTEMP_I,
  input wire logic TEMP_ABOVE_HYST_I,
  output logic LIMIT_ENABLE_O,
  output logic [7:0] LIMIT_MA_O,
  output logic LINE_HIGH_ON_O,
  output logic LINE_LOW_ON_O,
  output logic LINE_PULLUP_O,
  output logic LINE_PULLDOWN_O,
  output logic RX_O,
  output logic RX_OE_O,
  output logic AUX_HIGH_ON_O,
  output logic AUX_LOW_ON_O,
  output logic AUX_PULLUP_O,
  output logic AUX_PULLDOWN_O,
  output logic LINE_FAULT_FLAG_O,
  output logic AUX_FAULT_FLAG_O,
  output logic IRQ_O
);

  typedef struct packed {
    logic [7:0] limit_cfg;
    logic [7:0] line_cfg;
    logic [7:0] aux_cfg;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic ack;
    logic [7:0] rdata;
    logic limit_en;
    logic [7:0] limit_ma;
    logic line_hi;
    logic line_lo;
    logic aux_hi;
    logic aux_lo;
    logic rx;
    logic rx_oe;
  } regs_state_t;

  regs_state_t st;
  regs_state_t next_st;

  logic [3:0] idx;
  logic req;
  logic wr_fire;
  logic line_on;
  logic aux_on;
  logic line_flag;
  logic aux_flag;
  logic line_evt;
  logic aux_evt;
  logic line_hi_c;
  logic line_lo_c;
  logic aux_hi_c;
  logic aux_lo_c;
  logic aux_out_bit;
  logic aux_tx_en;
  logic aux_tx_data;
  logic [7:0] fault_status;
  logic [IRQ_W-1:0] irq_set;

  assign idx = AVS_ADDRESS_I[5:2];
  assign req = AVS_READ_I || AVS_WRITE_I;
  assign wr_fire = AVS_WRITE_I && st.ack && AVS_BYTEENABLE_I[0];
  assign fault_status = {6'h00, aux_flag, line_flag};
  assign irq_set = {aux_evt, line_evt};

  fault_timer #(
    .BLANK_CYC_0(BLANK_CYC_0), .BLANK_CYC_1(BLANK_CYC_1), .BLANK_CYC_2(BLANK_CYC_2), .BLANK_CYC_3(BLANK_CYC_3),
    .RETRY_CYC_0(RETRY_CYC_0), .RETRY_CYC_1(RETRY_CYC_1), .RETRY_CYC_2(RETRY_CYC_2), .RETRY_CYC_3(RETRY_CYC_3)
  ) u_line_timer (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .fault_cond_i(LINE_OVERCURRENT_I || LINE_OVERTEMP_I),
    .temp_above_hyst_i(TEMP_ABOVE_HYST_I),
    .auto_retry_i(st.limit_cfg[RETRY_EN]),
    .blank_sel_i(st.limit_cfg[BLK_SEL_LO+:2]),
    .retry_sel_i(st.limit_cfg[RTY_SEL_LO+:2]),
    .driver_on_o(line_on),
    .fault_flag_o(line_flag),
    .fault_event_o(line_evt)
  );

  fault_timer #(
    .BLANK_CYC_0(BLANK_CYC_0), .BLANK_CYC_1(BLANK_CYC_1), .BLANK_CYC_2(BLANK_CYC_2), .BLANK_CYC_3(BLANK_CYC_3),
    .RETRY_CYC_0(RETRY_CYC_0), .RETRY_CYC_1(RETRY_CYC_1), .RETRY_CYC_2(RETRY_CYC_2), .RETRY_CYC_3(RETRY_CYC_3)
  ) u_aux_timer (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .fault_cond_i(AUX_OVERCURRENT_I || AUX_OVERTEMP_I),
    .temp_above_hyst_i(TEMP_ABOVE_HYST_I),
    .auto_retry_i(st.limit_cfg[RETRY_EN]),
    .blank_sel_i(st.limit_cfg[BLK_SEL_LO+:2]),
    .retry_sel_i(st.limit_cfg[RTY_SEL_LO+:2]),
    .driver_on_o(aux_on),
    .fault_flag_o(aux_flag),
    .fault_event_o(aux_evt)
  );

  // With tracking on, the aux driver takes the line driver's source and enable.
  always_comb begin
    if (st.line_cfg[TRACK]) begin
      aux_out_bit = st.line_cfg[OUT_BIT];
      aux_tx_en = TRANSMIT_ENABLE_IN_I;
      aux_tx_data = TX_DATA_I;
    end else begin
      aux_out_bit = st.aux_cfg[OUT_BIT];
      aux_tx_en = 1'b1;
      aux_tx_data = AUX_LEVEL_I;
    end
  end

  drive_logic u_line_drive (
    .enable_i(line_on),
    .disable_i(st.line_cfg[DRV_DIS]),
    .out_bit_i(st.line_cfg[OUT_BIT]),
    .push_pull_i(st.line_cfg[PUSH_PULL]),
    .npn_i(st.line_cfg[NPN_SEL]),
    .tx_en_i(TRANSMIT_ENABLE_IN_I),
    .tx_data_i(TX_DATA_I),
    .high_on_o(line_hi_c),
    .low_on_o(line_lo_c)
  );

  drive_logic u_aux_drive (
    .enable_i(aux_on),
    .disable_i(st.aux_cfg[DRV_DIS]),
    .out_bit_i(aux_out_bit),
    .push_pull_i(st.aux_cfg[PUSH_PULL]),
    .npn_i(st.aux_cfg[NPN_SEL]),
    .tx_en_i(aux_tx_en),
    .tx_data_i(aux_tx_data),
    .high_on_o(aux_hi_c),
    .low_on_o(aux_lo_c)
  );

  always_comb begin
    next_st = st;
    // Every request is answered one cycle after it is first seen.
    next_st.ack = req && !st.ack;
    if (AVS_READ_I && !st.ack) begin
      case (idx)
        IDX_LIMIT_CFG: next_st.rdata = st.limit_cfg;
        IDX_LINE_CFG: next_st.rdata = st.line_cfg;
        IDX_AUX_CFG: next_st.rdata = st.aux_cfg;
        IDX_FAULT_STATUS: next_st.rdata = fault_status;
        IDX_IRQ_STATUS: next_st.rdata = {6'h00, st.irq_status};
        IDX_IRQ_MASK: next_st.rdata = {6'h00, st.irq_mask};
        default: next_st.rdata = 8'h00;
      endcase
    end
    next_st.irq_status = st.irq_status | irq_set;
    if (wr_fire) begin
      case (idx)
        IDX_LIMIT_CFG: next_st.limit_cfg = AVS_WRITEDATA_I[7:0];
        IDX_LINE_CFG: next_st.line_cfg = AVS_WRITEDATA_I[7:0];
        IDX_AUX_CFG: next_st.aux_cfg = AVS_WRITEDATA_I[7:0] & AUX_CFG_WMASK;
        // A fault event in the clearing cycle keeps its bit set.
        IDX_IRQ_STATUS: next_st.irq_status = (st.irq_status & ~AVS_WRITEDATA_I[IRQ_W-1:0]) | irq_set;
        IDX_IRQ_MASK: next_st.irq_mask = AVS_WRITEDATA_I[IRQ_W-1:0];
        default: next_st.irq_mask = st.irq_mask;
      endcase
    end
    next_st.limit_en = !st.limit_cfg[LIM_DIS];
    next_st.limit_ma = limit_ma(st.limit_cfg[LIM_SEL_LO+:2]);
    next_st.line_hi = line_hi_c;
    next_st.line_lo = line_lo_c;
    next_st.aux_hi = aux_hi_c;
    next_st.aux_lo = aux_lo_c;
    next_st.rx_oe = !st.line_cfg[RX_DIS];
    next_st.rx = LINE_RX_LEVEL_I && !st.line_cfg[RX_DIS];
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st <= '{limit_cfg: LIMIT_CFG_RESET, line_cfg: LINE_CFG_RESET, aux_cfg: AUX_CFG_RESET,
              irq_status: '0, irq_mask: '0, ack: 1'b0, rdata: 8'h00, limit_en: 1'b1, limit_ma: LIMIT_50_MA,
              line_hi: 1'b0, line_lo: 1'b0, aux_hi: 1'b0, aux_lo: 1'b0, rx: 1'b0, rx_oe: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign AVS_WAITREQUEST_O = req && !st.ack;
  assign AVS_READDATA_O = {24'h00_0000, st.rdata};
  assign LIMIT_ENABLE_O = st.limit_en;
  assign LIMIT_MA_O = st.limit_ma;
  assign LINE_HIGH_ON_O = st.line_hi;
  assign LINE_LOW_ON_O = st.line_lo;
  assign LINE_PULLUP_O = st.line_cfg[WPU];
  assign LINE_PULLDOWN_O = st.line_cfg[WPD];
  assign RX_O = st.rx;
  assign RX_OE_O = st.rx_oe;
  assign AUX_HIGH_ON_O = st.aux_hi;
  assign AUX_LOW_ON_O = st.aux_lo;
  assign AUX_PULLUP_O = st.aux_cfg[WPU];
  assign AUX_PULLDOWN_O = st.aux_cfg[WPD];
  assign LINE_FAULT_FLAG_O = line_flag;
  assign AUX_FAULT_FLAG_O = aux_flag;
  assign IRQ_O = |(st.irq_status & st.irq_mask);

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  a_limit_value: assert property (1'b1 |=> LIMIT_MA_O == limit_ma($past(st.limit_cfg[LIM_SEL_LO+:2])))
    else $error("current limit value does not follow selection");
  a_limit_off: assert property (st.limit_cfg[LIM_DIS] |=> !LIMIT_ENABLE_O)
    else $error("current limit still enabled while disabled");
  a_rx_hiz: assert property (st.line_cfg[RX_DIS] |=> !RX_OE_O && !RX_O)
    else $error("receiver output driven while disabled");
  a_line_dis_hiz: assert property (st.line_cfg[DRV_DIS] |=> !LINE_HIGH_ON_O && !LINE_LOW_ON_O)
    else $error("line driver on while disabled");
  a_line_idle_hiz: assert property (!st.line_cfg[OUT_BIT] && !TRANSMIT_ENABLE_IN_I
      |=> !LINE_HIGH_ON_O && !LINE_LOW_ON_O)
    else $error("line driver on with transmit enable low");
  a_line_inverts: assert property (line_on && st.line_cfg[PUSH_PULL] && !st.line_cfg[OUT_BIT]
      && !st.line_cfg[DRV_DIS] && TRANSMIT_ENABLE_IN_I |=> LINE_HIGH_ON_O == !$past(TX_DATA_I))
    else $error("line level is not the inverse of transmit data");
  a_npn_off: assert property (line_on && !st.line_cfg[PUSH_PULL] && st.line_cfg[NPN_SEL]
      && st.line_cfg[OUT_BIT] && !st.line_cfg[DRV_DIS] |=> !LINE_LOW_ON_O && !LINE_HIGH_ON_O)
    else $error("npn switch not off with output bit set");
  a_fault_off: assert property (!line_on |=> !LINE_HIGH_ON_O && !LINE_LOW_ON_O)
    else $error("line driver on during fault shutdown");
  a_wait_once: assert property (req && !st.ack |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
    else $error("bus answer not given in the second cycle");

endmodule : line_driver_control_regs

`default_nettype wire

// ==== verification/line_master_model.sv ====
// Model of the line master on the communication line: resolves the line level and can short it.
// Assumes the device's switch commands are registered on the bench clock.
`default_nettype none

module line_master_model #(
  parameter logic LOAD_LEVEL = 1'b0
) (
  input wire logic high_on_i,
  input wire logic low_on_i,
  input wire logic pullup_i,
  input wire logic pulldown_i,
  input wire logic short_i,
  output logic level_o,
  output logic overcurrent_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // An undriven line settles at the master's load unless only the device pull-up acts.
  assign level_o = high_on_i ? 1'b1 : low_on_i ? 1'b0 : (pullup_i & ~pulldown_i) ? 1'b1 : LOAD_LEVEL;
  assign overcurrent_o = short_i;
endmodule : line_master_model

`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the line driver control register bank.
// Assumes the design package is compiled first; fault timing is shortened by parameters.
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module testbench
  import ldc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = '0, rst_b = '0, rd = '0, wr = '0, txd = '0, transmit_enable_in = '0, auxl = '0, temp = '0, short_c = '0;
  logic lot = '0, aoc = '0, aot = '0;
  logic [3:0] be = 4'hf;
  logic [5:0] adr = '0;
  logic [31:0] wdat = '0, rdat;
  logic wreq, lvl, oc, lim_en, hi, lo, pu, pd, rx, rx_oe, ahi, alo, apu, apd, lf, af, irq;
  // Shortened blanking and off-time counts so that every selection code is reached quickly.
  localparam int BL[4] = '{4, 6, 8, 10};
  localparam int RT[4] = '{20, 30, 40, 50};
  logic [7:0] lim_ma, got;
  int failures = 0, n_checks = 0, cyc = 0;

  always #20 clk = ~clk;

  line_driver_control_regs #(
    .BLANK_CYC_0(CNT_W'(BL[0])), .BLANK_CYC_1(CNT_W'(BL[1])), .BLANK_CYC_2(CNT_W'(BL[2])),
    .BLANK_CYC_3(CNT_W'(BL[3])), .RETRY_CYC_0(CNT_W'(RT[0])), .RETRY_CYC_1(CNT_W'(RT[1])),
    .RETRY_CYC_2(CNT_W'(RT[2])), .RETRY_CYC_3(CNT_W'(RT[3]))
  ) u_dut (
    .CLK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
    .TX_DATA_I(txd), .TRANSMIT_ENABLE_IN_I(transmit_enable_in), .AUX_LEVEL_I(auxl), .LINE_RX_LEVEL_I(lvl),
    .LINE_OVERCURRENT_I(oc), .LINE_OVERTEMP_I(lot), .AUX_OVERCURRENT_I(aoc), .AUX_OVERTEMP_I(aot),
    .TEMP_ABOVE_HYST_I(temp), .LIMIT_ENABLE_O(lim_en), .LIMIT_MA_O(lim_ma), .LINE_HIGH_ON_O(hi),
    .LINE_LOW_ON_O(lo), .LINE_PULLUP_O(pu), .LINE_PULLDOWN_O(pd), .RX_O(rx), .RX_OE_O(rx_oe),
    .AUX_HIGH_ON_O(ahi), .AUX_LOW_ON_O(alo), .AUX_PULLUP_O(apu), .AUX_PULLDOWN_O(apd),
    .LINE_FAULT_FLAG_O(lf), .AUX_FAULT_FLAG_O(af), .IRQ_O(irq)
  );

  line_master_model u_master (
    .high_on_i(hi), .low_on_i(lo), .pullup_i(pu), .pulldown_i(pd), .short_i(short_c),
    .level_o(lvl), .overcurrent_o(oc)
  );

  task automatic final_report();
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  // Holds the request until waitrequest is sampled low, then takes read data at that edge.
  task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
    @(posedge clk);
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    wr <= w;
    rd <= ~w;
    do @(posedge clk); while (wreq !== 1'b0);
    got = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic t_reset();
    settle(1);
    `CHK("line_sw", 2'b00, {hi, lo});
    bus(1'b0, IDX_LINE_CFG, 8'h00);
    `CHK("line_cfg", 8'h01, got);
    bus(1'b0, IDX_LIMIT_CFG, 8'h00);
    `CHK("limit_cfg", 8'h00, got);
    bus(1'b0, 4'hf, 8'h00);
    `CHK("unmapped", 8'h00, got);
    bus(1'b1, IDX_AUX_CFG, 8'hff);
    bus(1'b0, IDX_AUX_CFG, 8'h00);
    `CHK("aux_cfg", 8'h7f, got);
    be <= 4'he;
    bus(1'b1, IDX_AUX_CFG, 8'h00);
    be <= 4'hf;
    bus(1'b0, IDX_AUX_CFG, 8'h00);
    `CHK("be_ignored", 8'h7f, got);
    `CHK("aux_pull", 2'b11, {apu, apd});
  endtask : t_reset

  task automatic t_limit();
    logic [7:0] ma[4] = '{8'h32, 8'h64, 8'hc8, 8'hfa};
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, IDX_LIMIT_CFG, {i[1:0], i[2], 5'h00});
      settle(2);
      `CHK("lim_ma", ma[i % 4], lim_ma);
      `CHK("lim_en", ~i[2], lim_en);
    end
  endtask : t_limit

  task automatic t_line();
    // Each entry is {line_cfg, enable, data, high switch, low switch}.
    logic [11:0] t[12] = '{12'h018, 12'h062, 12'h022, 12'h0a0, 12'h040, 12'h04a,
                           12'h04d, 12'h08d, 12'h0cd, 12'h038, 12'h00a, 12'h00c};
    foreach (t[i]) begin
      @(posedge clk);
      transmit_enable_in <= t[i][3];
      txd <= t[i][2];
      bus(1'b1, IDX_LINE_CFG, t[i][11:4]);
      settle(2);
      `CHK("line_sw", t[i][1:0], {hi, lo});
    end
  endtask : t_line

  task automatic t_rx();
    logic [7:0] c[4] = '{8'h06, 8'h86, 8'h21, 8'h41};
    logic [3:0] e[4] = '{4'hc, 4'h0, 4'he, 4'h5};
    foreach (c[i]) begin
      bus(1'b1, IDX_LINE_CFG, c[i]);
      settle(3);
      `CHK("rx_pull", e[i], {rx, rx_oe, pu, pd});
    end
  endtask : t_rx

  task automatic t_track();
    @(posedge clk);
    auxl <= 1'b1;
    bus(1'b1, IDX_AUX_CFG, 8'h04);
    bus(1'b1, IDX_LINE_CFG, 8'h16);
    settle(2);
    `CHK("aux_sw", 2'b10, {ahi, alo});
    bus(1'b1, IDX_LINE_CFG, 8'h06);
    settle(2);
    `CHK("aux_sw", 2'b01, {ahi, alo});
  endtask : t_track

  task automatic t_retry();
    int off;
    bus(1'b1, IDX_IRQ_MASK, 8'h01);
    bus(1'b1, IDX_LIMIT_CFG, 8'h01);
    @(posedge clk);
    short_c <= 1'b1;
    aot <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    short_c <= 1'b0;
    aot <= 1'b0;
    settle(12);
    `CHK("short", 3'b001, {lf, af, hi});
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, IDX_LIMIT_CFG, {3'b000, i[1:0], i[1:0], 1'b1});
      @(posedge clk);
      short_c <= 1'b1;
      settle(BL[i]);
      `CHK("flag_early", 1'b0, lf);
      settle(1);
      `CHK("flag", 1'b1, lf);
      @(posedge clk);
      short_c <= 1'b0;
      // The switch output falls in this edge's update, so counting starts at the following negedge.
      @(negedge clk);
      off = 0;
      while (hi !== 1'b1 && off < 200) begin
        off++;
        @(negedge clk);
      end
      `CHK("off_time", RT[i], off);
      `CHK("flag_clr", 1'b0, lf);
    end
    `CHK("irq", 1'b1, irq);
    bus(1'b1, IDX_IRQ_MASK, 8'h00);
    settle(1);
    `CHK("irq_mask", 1'b0, irq);
    bus(1'b1, IDX_IRQ_MASK, 8'h01);
    bus(1'b1, IDX_IRQ_STATUS, 8'h01);
    settle(1);
    `CHK("irq_clr", 1'b0, irq);
  endtask : t_retry

  task automatic t_hot();
    bus(1'b1, IDX_LIMIT_CFG, 8'h00);
    @(posedge clk);
    temp <= 1'b1;
    lot <= 1'b1;
    aoc <= 1'b1;
    settle(8);
    `CHK("hot_flag", 2'b11, {lf, af});
    @(posedge clk);
    lot <= 1'b0;
    aoc <= 1'b0;
    settle(60);
    `CHK("hot_off", 3'b000, {hi, ahi, alo});
    @(posedge clk);
    temp <= 1'b0;
    settle(4);
    `CHK("cool_on", 3'b101, {hi, ahi, alo});
  endtask : t_hot

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_limit();
    t_line();
    t_rx();
    t_track();
    t_retry();
    t_hot();
    final_report();
  end
endmodule : testbench

`default_nettype wire
